// ---- rtl/pif_pkg.sv ----
//------------------------------------------------------------------
//------------------------------------------------------------------
package pif_pkg;
   // register offsets
   localparam logic [7:0] REG_BATCOMP_CTRL = 8'h04;
   localparam logic [7:0] REG_CHG_MASK = 8'h0D;
   localparam logic [7:0] REG_STATE_MASK = 8'h0E;
   localparam logic [7:0] REG_PIN_MASK = 8'h0F;
   localparam logic [7:0] REG_CHG_FLAGS = 8'h10;
   localparam logic [7:0] REG_STATE_FLAGS = 8'h11;
   localparam logic [7:0] REG_PIN_FLAGS = 8'h12;
   // values after reset
   localparam logic [7:0] MASK_RST = 8'hFF;
   localparam logic [7:0] FLAG_RST = 8'h00;
   localparam logic [7:0] BATCOMP_CTRL_RST = 8'h02;
   localparam logic [7:0] RDATA_RST = 8'h00;
   // field positions and layouts
   localparam int BATCOMP_EN_BIT = 1;
   localparam int BATCOMP_FLAG_BIT = 1;
   localparam logic [7:0] BATCOMP_CTRL_WMASK = 8'h02;
   localparam logic [7:0] CHG_VALID = 8'hEF;
   localparam logic [7:0] STATE_VALID = 8'hFF;
   localparam logic [7:0] PIN_VALID = 8'hFE;
   localparam logic [7:0] PIN_MASK_RO = 8'h01;
   localparam logic [7:0] CHG_BOTH = 8'h0C;
   localparam logic [7:0] STATE_BOTH = 8'h00;
   localparam logic [7:0] PIN_BOTH = 8'hF2;
   // synchroniser layout and fill count
   localparam int SRC_W = 25;
   localparam int UNDERVOLTAGE_LOCKOUT_POS = 24;
   localparam logic [1:0] SYNC_PRIME = 2'h3;
endpackage : pif_pkg

// ---- rtl/pif_sync_edge.sv ----
`timescale 1ns/1ps
module pif_sync_edge #(
   parameter int W = pif_pkg::SRC_W
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] level_o,
   output logic [W-1:0] rise_o,
   output logic [W-1:0] fall_o
);
   logic [W-1:0] meta;
   logic [W-1:0] sync2;
   logic [W-1:0] sync3;
   logic [W-1:0] stable;
   logic [W-1:0] rise;
   logic [W-1:0] fall;
   logic [1:0] prime_cnt;
   logic [W-1:0] next_stable;
   logic [W-1:0] next_rise;
   logic [W-1:0] next_fall;
   logic [1:0] next_prime_cnt;

   // accept a new level once stages two and three agree
   always_comb begin
      next_stable = stable;
      next_rise = '0;
      next_fall = '0;
      next_prime_cnt = prime_cnt;
      if (prime_cnt != pif_pkg::SYNC_PRIME) begin
         next_prime_cnt = prime_cnt + 2'h1;
         next_stable = sync2; // load stage two, no edges while filling
      end else begin
         for (int i = 0; i < W; i++) begin
            if (sync2[i] == sync3[i]) begin
               next_stable[i] = sync3[i];
            end
         end
         next_rise = next_stable & ~stable;
         next_fall = stable & ~next_stable;
      end
   end

   // three-stage chain and edge registers
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         meta <= '0;
         sync2 <= '0;
         sync3 <= '0;
         stable <= '0;
         rise <= '0;
         fall <= '0;
         prime_cnt <= '0;
      end else if (ce_i) begin
         meta <= async_i;
         sync2 <= meta;
         sync3 <= sync2;
         stable <= next_stable;
         rise <= next_rise;
         fall <= next_fall;
         prime_cnt <= next_prime_cnt;
      end
   end

   assign level_o = stable;
   assign rise_o = rise;
   assign fall_o = fall;
endmodule : pif_sync_edge

// ---- rtl/pif_top.sv ----
`timescale 1ns/1ps
module pif_top (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic battery_comp_enable_o,
   input wire logic battery_too_hot_i,
   input wire logic battery_too_cold_i,
   input wire logic input_overvoltage_i,
   input wire logic charging_active_i,
   input wire logic input_power_good_i,
   input wire logic battery_comparator_i,
   input wire logic thermal_regulation_active_i,
   input wire logic charger_sleep_state_i,
   input wire logic charger_reset_state_i,
   input wire logic charger_idle_state_i,
   input wire logic charger_precharge_state_i,
   input wire logic charger_const_current_voltage_state_i,
   input wire logic charger_linear_state_i,
   input wire logic battery_fault_i,
   input wire logic thermal_suspend_indication_i,
   input wire logic [3:0] gpio_status_i,
   input wire logic buck_not_power_good_i,
   input wire logic linreg_not_power_good_i,
   input wire logic push_button_status_i,
   input wire logic undervoltage_lockout_i
);
   //---------------------------------------------------------------
   // source synchronisation
   //---------------------------------------------------------------
   logic [pif_pkg::SRC_W-1:0] src;
   logic [pif_pkg::SRC_W-1:0] level;
   logic [pif_pkg::SRC_W-1:0] rise;
   logic [pif_pkg::SRC_W-1:0] fall;
   logic undervoltage_lockout;

   // sources packed in flag-register bit order, reserved bits tied low
   assign src = {undervoltage_lockout_i,
                 gpio_status_i, buck_not_power_good_i,
                 linreg_not_power_good_i, push_button_status_i, 1'b0,
                 charger_sleep_state_i, charger_reset_state_i,
                 charger_idle_state_i, charger_precharge_state_i,
                 charger_const_current_voltage_state_i,
                 charger_linear_state_i, battery_fault_i,
                 thermal_suspend_indication_i,
                 battery_too_hot_i, battery_too_cold_i,
                 input_overvoltage_i, 1'b0, charging_active_i,
                 input_power_good_i, battery_comparator_i,
                 thermal_regulation_active_i};

   pif_sync_edge #(.W(pif_pkg::SRC_W)) u_sync (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .async_i(src),
      .level_o(level),
      .rise_o(rise),
      .fall_o(fall)
   );

   assign undervoltage_lockout = level[pif_pkg::UNDERVOLTAGE_LOCKOUT_POS];

   //---------------------------------------------------------------
   // event qualification
   //---------------------------------------------------------------
   function automatic logic [7:0] pif_event(
      input logic [7:0] r,
      input logic [7:0] f,
      input logic [7:0] both,
      input logic [7:0] valid,
      input logic [7:0] mask
   );
      pif_event = (r | (f & both)) & valid & ~mask;
   endfunction : pif_event

   logic [7:0] chg_mask;
   logic [7:0] state_mask;
   logic [7:0] pin_mask;
   logic [7:0] bat_ctrl;
   logic [7:0] chg_flags;
   logic [7:0] state_flags;
   logic [7:0] pin_flags;
   logic [7:0] rdata;
   logic [7:0] chg_evt;
   logic [7:0] state_evt;
   logic [7:0] pin_evt;
   logic bat_en;
   logic rd_chg;
   logic rd_state;
   logic rd_pin;

   assign bat_en = bat_ctrl[pif_pkg::BATCOMP_EN_BIT];

   // per-register events, masks gate them
   always_comb begin
      chg_evt = pif_event(rise[7:0], fall[7:0], pif_pkg::CHG_BOTH,
                          pif_pkg::CHG_VALID, chg_mask);
      if (!bat_en) begin
         chg_evt[pif_pkg::BATCOMP_FLAG_BIT] = 1'b0;
      end
      state_evt = pif_event(rise[15:8], fall[15:8], pif_pkg::STATE_BOTH,
                            pif_pkg::STATE_VALID,
                            state_mask);
      pin_evt = pif_event(rise[23:16], fall[23:16], pif_pkg::PIN_BOTH,
                          pif_pkg::PIN_VALID,
                          pin_mask);
   end

   //---------------------------------------------------------------
   // register file
   //---------------------------------------------------------------
   logic [7:0] next_chg_mask;
   logic [7:0] next_state_mask;
   logic [7:0] next_pin_mask;
   logic [7:0] next_bat_ctrl;
   logic [7:0] next_chg_flags;
   logic [7:0] next_state_flags;
   logic [7:0] next_pin_flags;
   logic [7:0] next_rdata;

   assign rd_chg = reg_rd_i && (reg_addr_i == pif_pkg::REG_CHG_FLAGS);
   assign rd_state = reg_rd_i && (reg_addr_i == pif_pkg::REG_STATE_FLAGS);
   assign rd_pin = reg_rd_i && (reg_addr_i == pif_pkg::REG_PIN_FLAGS);

   // masks and comparator enable writes
   always_comb begin
      next_chg_mask = chg_mask;
      next_state_mask = state_mask;
      next_pin_mask = pin_mask;
      next_bat_ctrl = bat_ctrl;
      if (undervoltage_lockout) begin
         next_chg_mask = pif_pkg::MASK_RST;
         next_state_mask = pif_pkg::MASK_RST;
         next_pin_mask = pif_pkg::MASK_RST;
         next_bat_ctrl = pif_pkg::BATCOMP_CTRL_RST;
      end else if (reg_wr_i) begin
         if (reg_addr_i == pif_pkg::REG_BATCOMP_CTRL) begin
            next_bat_ctrl = reg_wdata_i & pif_pkg::BATCOMP_CTRL_WMASK;
         end else if (reg_addr_i == pif_pkg::REG_CHG_MASK) begin
            next_chg_mask = reg_wdata_i;
         end else if (reg_addr_i == pif_pkg::REG_STATE_MASK) begin
            next_state_mask = reg_wdata_i;
         end else if (reg_addr_i == pif_pkg::REG_PIN_MASK) begin
            next_pin_mask = reg_wdata_i | pif_pkg::PIN_MASK_RO;
         end
      end
   end

   // sticky flags: read clears, new event wins over the clear
   always_comb begin
      if (undervoltage_lockout) begin
         next_chg_flags = pif_pkg::FLAG_RST;
         next_state_flags = pif_pkg::FLAG_RST;
         next_pin_flags = pif_pkg::FLAG_RST;
      end else begin
         next_chg_flags = (chg_flags & ~{8{rd_chg}})
                          | chg_evt;
         next_state_flags = (state_flags & ~{8{rd_state}})
                            | state_evt;
         next_pin_flags = (pin_flags & ~{8{rd_pin}})
                          | pin_evt;
      end
   end

   // read data, held between reads, unmapped reads 00
   always_comb begin
      next_rdata = rdata;
      if (reg_rd_i) begin
         if (reg_addr_i == pif_pkg::REG_BATCOMP_CTRL) begin
            next_rdata = bat_ctrl;
         end else if (reg_addr_i == pif_pkg::REG_CHG_MASK) begin
            next_rdata = chg_mask;
         end else if (reg_addr_i == pif_pkg::REG_STATE_MASK) begin
            next_rdata = state_mask;
         end else if (reg_addr_i == pif_pkg::REG_PIN_MASK) begin
            next_rdata = pin_mask;
         end else if (reg_addr_i == pif_pkg::REG_CHG_FLAGS) begin
            next_rdata = chg_flags;
         end else if (reg_addr_i == pif_pkg::REG_STATE_FLAGS) begin
            next_rdata = state_flags;
         end else if (reg_addr_i == pif_pkg::REG_PIN_FLAGS) begin
            next_rdata = pin_flags;
         end else begin
            next_rdata = pif_pkg::RDATA_RST;
         end
      end
   end

   // register stage
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         chg_mask <= pif_pkg::MASK_RST;
         state_mask <= pif_pkg::MASK_RST;
         pin_mask <= pif_pkg::MASK_RST;
         bat_ctrl <= pif_pkg::BATCOMP_CTRL_RST;
         chg_flags <= pif_pkg::FLAG_RST;
         state_flags <= pif_pkg::FLAG_RST;
         pin_flags <= pif_pkg::FLAG_RST;
         rdata <= pif_pkg::RDATA_RST;
      end else if (ce_i) begin
         chg_mask <= next_chg_mask;
         state_mask <= next_state_mask;
         pin_mask <= next_pin_mask;
         bat_ctrl <= next_bat_ctrl;
         chg_flags <= next_chg_flags;
         state_flags <= next_state_flags;
         pin_flags <= next_pin_flags;
         rdata <= next_rdata;
      end
   end

   assign reg_rdata_o = rdata;
   assign battery_comp_enable_o = bat_en;

   //---------------------------------------------------------------
   // checks
   //---------------------------------------------------------------
   property p_chg_clear;
      @(posedge ref_clk_i) disable iff (srst_i)
      (ce_i && rd_chg && !undervoltage_lockout && chg_evt == 8'h00)
      |=> (chg_flags == 8'h00);
   endproperty
   a_chg_clear: assert property (p_chg_clear)
      else $error("charger flags not cleared by read");

   property p_batcomp_off;
      @(posedge ref_clk_i) disable iff (srst_i)
      (ce_i && !bat_en && !chg_flags[1]) |=> !chg_flags[1];
   endproperty
   a_batcomp_off: assert property (p_batcomp_off)
      else $error("comparator flag set while disabled");

   property p_state_hold;
      @(posedge ref_clk_i) disable iff (srst_i)
      (!(ce_i && (rd_state || undervoltage_lockout)))
      |=> ((state_flags & $past(state_flags)) == $past(state_flags));
   endproperty
   a_state_hold: assert property (p_state_hold)
      else $error("state flag dropped without read");

   property p_sleep_set;
      @(posedge ref_clk_i) disable iff (srst_i)
      (ce_i && rise[15] && !state_mask[7] && !undervoltage_lockout) |=> state_flags[7];
   endproperty
   a_sleep_set: assert property (p_sleep_set)
      else $error("sleep flag not set on rising edge");

   property p_suspend_set;
      @(posedge ref_clk_i) disable iff (srst_i)
      (ce_i && rise[8] && !state_mask[0] && !undervoltage_lockout) |=> state_flags[0];
   endproperty
   a_suspend_set: assert property (p_suspend_set)
      else $error("suspend flag not set on rising edge");

   property p_undervoltage_lockout_clear;
      @(posedge ref_clk_i) disable iff (srst_i)
      (ce_i && undervoltage_lockout) |=> ({chg_flags, state_flags, pin_flags} == 24'h0
                         && chg_mask == 8'hFF);
   endproperty
   a_undervoltage_lockout_clear: assert property (p_undervoltage_lockout_clear)
      else $error("lockout did not clear flags");

   property p_gpio_fall;
      @(posedge ref_clk_i) disable iff (srst_i)
      (ce_i && fall[23] && !pin_mask[7] && !undervoltage_lockout) |=> pin_flags[7];
   endproperty
   a_gpio_fall: assert property (p_gpio_fall)
      else $error("pin flag missed falling edge");

   property p_pgood_fall;
      @(posedge ref_clk_i) disable iff (srst_i)
      (ce_i && fall[19] && !rise[19] && !pin_flags[3]) |=> !pin_flags[3];
   endproperty
   a_pgood_fall: assert property (p_pgood_fall)
      else $error("power good flag set on falling edge");

   property p_button_fall;
      @(posedge ref_clk_i) disable iff (srst_i)
      (ce_i && fall[17] && !pin_mask[1] && !undervoltage_lockout) |=> pin_flags[1];
   endproperty
   a_button_fall: assert property (p_button_fall)
      else $error("button flag missed falling edge");

   property p_active_fall;
      @(posedge ref_clk_i) disable iff (srst_i)
      (ce_i && fall[3] && !chg_mask[3] && !undervoltage_lockout) |=> chg_flags[3];
   endproperty
   a_active_fall: assert property (p_active_fall)
      else $error("active flag missed falling edge");

   property p_set_wins;
      @(posedge ref_clk_i) disable iff (srst_i)
      (ce_i && rd_pin && pin_evt != 8'h00 && !undervoltage_lockout)
      |=> ((pin_flags & $past(pin_evt)) == $past(pin_evt))
      ##1 (!$past(ce_i && rd_pin)
           || ((reg_rdata_o & $past(pin_evt, 2)) == $past(pin_evt, 2)));
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event lost during read");
endmodule : pif_top

// ---- testbench/pif_host.sv ----
`timescale 1ns/1ps
// host model on the far side of the register strobe port
module pif_host (
   input wire logic ref_clk_i,
   input wire logic [7:0] reg_rdata_i,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   output logic reg_wr_o,
   output logic reg_rd_o
);
   // idle bus from time zero
   initial begin
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
   end

   // masks and enable are written, and the state flags once, never a regulator
   // one write strobe; data is scrambled once released
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= v;
      reg_wr_o <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_o <= 1'b0;
      reg_wdata_o <= ~v;
   endtask : wr

   // one read strobe; data taken at the edge after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge ref_clk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
      @(posedge ref_clk_i);
      v = reg_rdata_i;
   endtask : rd

   // back-to-back reads, OR of everything returned
   task automatic burst(input logic [7:0] a, input int n,
                        output logic [7:0] acc);
      acc = 8'h00;
      @(posedge ref_clk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge ref_clk_i);
      repeat (n - 1) begin
         @(posedge ref_clk_i);
         acc = acc | reg_rdata_i;
      end
      reg_rd_o <= 1'b0;
      @(posedge ref_clk_i);
      acc = acc | reg_rdata_i;
   endtask : burst
endmodule : pif_host

// ---- testbench/tb_pif_top.sv ----
`timescale 1ns/1ps
module tb_pif_top;
   logic ref_clk_i;
   logic srst_i;
   logic [7:0] addr, wdata, rdata;
   logic wr, rd, comp_en;
   logic [6:0] chg;
   logic [7:0] st;
   logic [3:0] gp;
   logic buck, lin, pb, undervoltage_lockout;
   logic ce;
   logic [7:0] d;
   int fails = 0;
   int total_checks = 0;

   // ------------------------------------------------------------
   // clock, design and host
   // ------------------------------------------------------------
   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end

   pif_top dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .ce_i(ce),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdata),
      .battery_comp_enable_o(comp_en),
      .battery_too_hot_i(chg[6]), .battery_too_cold_i(chg[5]),
      .input_overvoltage_i(chg[4]), .charging_active_i(chg[3]),
      .input_power_good_i(chg[2]), .battery_comparator_i(chg[1]),
      .thermal_regulation_active_i(chg[0]),
      .charger_sleep_state_i(st[7]), .charger_reset_state_i(st[6]),
      .charger_idle_state_i(st[5]), .charger_precharge_state_i(st[4]),
      .charger_const_current_voltage_state_i(st[3]),
      .charger_linear_state_i(st[2]), .battery_fault_i(st[1]),
      .thermal_suspend_indication_i(st[0]), .gpio_status_i(gp),
      .buck_not_power_good_i(buck), .linreg_not_power_good_i(lin),
      .push_button_status_i(pb), .undervoltage_lockout_i(undervoltage_lockout));

   pif_host host (.ref_clk_i(ref_clk_i), .reg_rdata_i(rdata),
      .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
      .reg_rd_o(rd));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // read one register and compare
   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      host.rd(a, v);
      check(v, exp);
   endtask : rc

   // let an input change pass the synchroniser
   task automatic settle();
      repeat (8) @(posedge ref_clk_i);
   endtask : settle

   task automatic tally_and_finish();
      if (fails == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset_vals();
      rc(8'h0D, 8'hFF);
      rc(8'h0E, 8'hFF);
      rc(8'h0F, 8'hFF);
      rc(8'h04, 8'h02);
      rc(8'h10, 8'h00);
      rc(8'h11, 8'h00);
      rc(8'h12, 8'h00);
      rc(8'h3A, 8'h00);
   endtask : t_reset_vals

   task automatic t_states();
      st <= 8'hFF;
      settle();
      rc(8'h11, 8'h00);
      st <= 8'h00;
      host.wr(8'h0E, 8'h00);
      host.wr(8'h11, 8'hFF);
      settle();
      st <= 8'hFF;
      settle();
      rc(8'h11, 8'hFF);
      rc(8'h11, 8'h00);
      st <= 8'h00;
      settle();
      rc(8'h11, 8'h00);
   endtask : t_states

   task automatic t_charger();
      host.wr(8'h0D, 8'h00);
      chg <= 7'h7F;
      settle();
      rc(8'h10, 8'hEF);
      rc(8'h10, 8'h00);
      chg <= 7'h00;
      settle();
      rc(8'h10, 8'h0C);
      host.wr(8'h04, 8'h00);
      @(posedge ref_clk_i);
      check({7'h00, comp_en}, 8'h00);
      chg[1] <= 1'b1;
      settle();
      rc(8'h10, 8'h00);
      rc(8'h04, 8'h00);
      host.wr(8'h04, 8'h02);
      chg[1] <= 1'b0;
      settle();
   endtask : t_charger

   task automatic t_pins();
      host.wr(8'h0F, 8'h00);
      rc(8'h0F, 8'h01);
      gp <= 4'hF;
      settle();
      rc(8'h12, 8'hF0);
      gp <= 4'h0;
      settle();
      rc(8'h12, 8'hF0);
      buck <= 1'b1;
      lin <= 1'b1;
      settle();
      rc(8'h12, 8'h0C);
      buck <= 1'b0;
      lin <= 1'b0;
      pb <= 1'b1;
      settle();
      rc(8'h12, 8'h02);
      pb <= 1'b0;
      settle();
      rc(8'h12, 8'h02);
      host.wr(8'h0F, 8'h02);
      pb <= 1'b1;
      settle();
      rc(8'h12, 8'h00);
   endtask : t_pins

   // reads every cycle while the event lands
   task automatic t_coincide();
      host.wr(8'h0F, 8'h00);
      pb <= 1'b0;
      host.burst(8'h12, 12, d);
      check(d, 8'h02);
      rc(8'h12, 8'h00);
   endtask : t_coincide

   // frozen enable hides a pulse, then passes a held level once free
   task automatic t_enable();
      ce <= 1'b0;
      st <= 8'hFF;
      settle();
      st <= 8'h00;
      settle();
      ce <= 1'b1;
      settle();
      rc(8'h11, 8'h00);
      ce <= 1'b0;
      st <= 8'h01;
      settle();
      ce <= 1'b1;
      settle();
      rc(8'h11, 8'h01);
      st <= 8'h00;
      settle();
   endtask : t_enable

   task automatic t_lockout();
      st <= 8'hFF;
      host.wr(8'h04, 8'h00);
      settle();
      undervoltage_lockout <= 1'b1;
      settle();
      undervoltage_lockout <= 1'b0;
      settle();
      rc(8'h11, 8'h00);
      rc(8'h0E, 8'hFF);
      rc(8'h04, 8'h02);
   endtask : t_lockout

   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      srst_i = 1'b1;
      ce = 1'b1;
      chg = 7'h00;
      st = 8'h00;
      gp = 4'h0;
      buck = 1'b0;
      lin = 1'b0;
      pb = 1'b0;
      undervoltage_lockout = 1'b0;
      repeat (4) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      settle();
      t_reset_vals();
      t_states();
      t_enable();
      t_charger();
      t_pins();
      t_coincide();
      t_lockout();
      tally_and_finish();
   end

   // cut a hang short
   initial begin
      repeat (5000) @(posedge ref_clk_i);
      fails++;
      tally_and_finish();
   end
endmodule : tb_pif_top
